// ==== epcs_pkg.sv ====
// Package of constants and types for the power condition subcommand block
package epcs_pkg;
    // ==========================================================
    // Register byte offsets
    // ==========================================================
    localparam logic [7:0] CMD_OFF = 8'h00; // Command block: feature/count/number
    localparam logic [7:0] CTRL_OFF = 8'h04; // Support and changeable masks
    localparam logic [7:0] STAT_OFF = 8'h08; // Status, error, feature state
    localparam logic [7:0] TMR_OFF = 8'h0c; // Timer enable view
    localparam logic [7:0] DEF_OFF = 8'h10; // Default timer setting write, condition index in data bits 17:16
    localparam logic [7:0] SAV_OFF = 8'h14; // Saved setting write
    localparam logic [7:0] CUR_OFF = 8'h18; // Current setting readback
    // ==========================================================
    // Command fields
    // ==========================================================
    localparam int SN_EN_BIT = 5; // Enable flag
    localparam int SN_SAVE_BIT = 4; // Save flag
    localparam logic [3:0] SUB_STATE = 4'h3; // Set state subcommand
    localparam logic [3:0] SUB_ENABLE = 4'h4; // Feature set on
    localparam logic [3:0] SUB_DISABLE = 4'h5; // Feature set off
    localparam logic [7:0] FEAT_EPC = 8'h4a; // Feature code for these subcommands
    localparam int NCOND = 4; // Power conditions tracked
    localparam int ID_WORD = 120; // Identify word holding capability bit
    localparam int ID_BIT = 7; // Capability bit position
    // ==========================================================
    // Status and error bits
    // ==========================================================
    localparam int ST_BSY = 7;
    localparam int ST_RDY = 6;
    localparam int ST_ERR = 0;
    localparam int ER_ABT = 2;
    // ==========================================================
    // Reset values
    // ==========================================================
    localparam logic [7:0] STATUS_RST = 8'h40; // Ready, not busy
    localparam logic [15:0] DEF_TIMER_RST = 16'h0001; // Plain default
    // Command word carried to the decoder
    typedef struct packed {
        logic [7:0] feature;
        logic [7:0] count;
        logic [7:0] number;
    } epcs_cmd_t;
endpackage : epcs_pkg

// ==== epcs_top.sv ====
// Power condition subcommand interpreter with an AHB-Lite register slave
// ==========================================================
// Behaviour
// RULE1: Sector number bit 5 enables condition
// RULE2: Sector number bit 4 requests save
// RULE3: Code 3h selects set-state subcommand
// RULE4: Abort on unchangeable, unsupported or disabling
// RULE5: Abort save on unsavable condition
// RULE6: Aborted command changes no settings
// RULE7: Success sets current enable; save copies it
// RULE8: Host puts condition id in count
// RULE9: Code 4h selects feature enable
// RULE10: Enable sets feature, identify bit, ADVANCED_POWER_MGMT off
// RULE11: Load current from default or saved
// RULE12: Start timer when nonzero and enabled
// RULE13: Enabled state survives every reset
// RULE14: Abort enable when feature unsupported
// RULE15: Code 5h selects feature disable
// RULE16: Disable stops timers, clears identify bit
// RULE17: Disabled state survives every reset
// RULE18: Abort disable if unsupported or disabling
// RULE19: Abort sets error bits; completion clears busy
//
// The register addresses and the AHB-Lite interface to the registers were decided locally.
`timescale 1ns/1ps
`default_nettype none
module epcs_top (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    output logic extended_power_conditions_on,
    output logic advanced_power_mgmt_on,
    output logic [3:0] timer_run,
    // Stored copy of the feature state, as kept in nonvolatile memory
    input wire logic nv_feature_on,
    output logic nv_feature_wr,
    output logic nv_feature_val
);
    // ==========================================================
    // Bus address phase capture
    // ==========================================================
    logic wr_q;
    logic rd_q;
    logic [7:0] addr_q;
    logic [31:0] rdata_q;
    logic cmd_go;
    epcs_pkg::epcs_cmd_t cmd;
    logic [3:0] support_q; // Conditions supported
    logic [3:0] change_q; // Conditions changeable
    logic [3:0] savable_q; // Conditions savable
    logic feat_sup_q; // Feature set supported
    logic disabling_q; // Feature set in process of disabling
    logic feat_q; // Feature set on
    logic apm_q;
    logic id_bit_q; // Identify word capability bit
    logic [3:0] cur_en_q; // Current timer enabled
    logic [3:0] sav_en_q; // Saved timer enabled
    logic [15:0] def_set_q [epcs_pkg::NCOND]; // Default timer settings
    logic [15:0] sav_set_q [epcs_pkg::NCOND]; // Saved timer settings
    logic [15:0] cur_set_q [epcs_pkg::NCOND]; // Current timer settings
    logic [3:0] run_q;
    logic [7:0] status_q;
    logic [7:0] error_q;
    logic nv_wr_q;
    logic nv_val_q;
    logic boot_q; // High once the stored feature state was taken
    logic abort;
    logic [1:0] cid;
    logic [3:0] sub;
    logic is_state;
    logic is_en;
    logic is_dis;
    logic ok_state;
    logic ok_en;
    logic ok_dis;

    assign cid = cmd.count[1:0];
    assign sub = cmd.number[3:0];

    // Address phase taken when selected and ready; NONSEQ and SEQ both count
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_q <= 1'b0;
            rd_q <= 1'b0;
            addr_q <= 8'h00;
        end else if (hready) begin
            wr_q <= hsel && htrans[1] && hwrite;
            rd_q <= hsel && htrans[1] && !hwrite;
            addr_q <= haddr[7:0];
        end
    end

    // Zero-wait slave, always OKAY
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end else begin
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end
    end

    // Writing the command word launches the subcommand
    assign cmd_go = wr_q && (addr_q == epcs_pkg::CMD_OFF);
    assign cmd = hwdata[23:0];

    // ==========================================================
    // Subcommand decode and checks
    // ==========================================================
    always_comb begin
        is_state = (cmd.feature == epcs_pkg::FEAT_EPC)
            && (sub == epcs_pkg::SUB_STATE); // RULE3 RULE8
        is_en = (cmd.feature == epcs_pkg::FEAT_EPC)
            && (sub == epcs_pkg::SUB_ENABLE); // RULE9
        is_dis = (cmd.feature == epcs_pkg::FEAT_EPC)
            && (sub == epcs_pkg::SUB_DISABLE); // RULE15
        ok_state = support_q[cid] && change_q[cid] && !disabling_q
            && !(cmd.number[epcs_pkg::SN_SAVE_BIT]
                 && !savable_q[cid]); // RULE4 RULE5
        ok_en = feat_sup_q; // RULE14
        ok_dis = feat_sup_q && !disabling_q; // RULE18
        // Unknown subcodes are refused too
        abort = cmd_go && !((is_state && ok_state) || (is_en && ok_en)
            || (is_dis && ok_dis));
    end

    // ==========================================================
    // Software-written configuration
    // ==========================================================
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            support_q <= 4'hf;
            change_q <= 4'hf;
            savable_q <= 4'hf;
            feat_sup_q <= 1'b1;
            disabling_q <= 1'b0;
        end else if (wr_q && addr_q == epcs_pkg::CTRL_OFF) begin
            support_q <= hwdata[3:0];
            change_q <= hwdata[7:4];
            savable_q <= hwdata[11:8];
            feat_sup_q <= hwdata[12];
            disabling_q <= hwdata[13];
        end
    end

    // Default and saved timer settings, one write per condition
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            for (int i = 0; i < epcs_pkg::NCOND; i++) begin
                def_set_q[i] <= epcs_pkg::DEF_TIMER_RST;
                sav_set_q[i] <= 16'h0000;
            end
        end else if (wr_q && addr_q == epcs_pkg::DEF_OFF) begin
            def_set_q[hwdata[17:16]] <= hwdata[15:0];
        end else if (wr_q && addr_q == epcs_pkg::SAV_OFF) begin
            sav_set_q[hwdata[17:16]] <= hwdata[15:0];
        end
    end

    // ==========================================================
    // Feature state; the persistent copy is restored after reset
    // ==========================================================
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            boot_q <= 1'b0;
            feat_q <= 1'b0;
            apm_q <= 1'b1;
            id_bit_q <= 1'b0;
        end else if (!boot_q) begin
            // Stored state survives resets in both directions
            boot_q <= 1'b1;
            feat_q <= nv_feature_on; // RULE13 RULE17
            id_bit_q <= nv_feature_on;
            apm_q <= !nv_feature_on;
        end else if (cmd_go && !abort && is_en) begin
            feat_q <= 1'b1; // RULE10
            id_bit_q <= 1'b1; // RULE10
            apm_q <= 1'b0; // RULE10
        end else if (cmd_go && !abort && is_dis) begin
            feat_q <= 1'b0; // RULE16
            id_bit_q <= 1'b0; // RULE16
        end
    end

    // Pulse to the nonvolatile store on every enable or disable command that is not aborted; the restore after reset sends none
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            nv_wr_q <= 1'b0;
            nv_val_q <= 1'b0;
        end else begin
            nv_wr_q <= cmd_go && !abort && (is_en || is_dis); // RULE13 RULE17
            nv_val_q <= is_en;
        end
    end

    // ==========================================================
    // Timer enables, settings and run flags
    // ==========================================================
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cur_en_q <= 4'hf;
            sav_en_q <= 4'hf;
        end else if (cmd_go && !abort && is_state) begin
            // Abort path never reaches here
            cur_en_q[cid] <= cmd.number[epcs_pkg::SN_EN_BIT]; // RULE1 RULE7 RULE6
            if (cmd.number[epcs_pkg::SN_SAVE_BIT]) begin
                sav_en_q[cid] <= cmd.number[epcs_pkg::SN_EN_BIT]; // RULE2 RULE7
            end
        end
    end

    // Current setting loaded on enable
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            for (int i = 0; i < epcs_pkg::NCOND; i++) begin
                cur_set_q[i] <= 16'h0000;
            end
        end else if (cmd_go && !abort && is_en) begin
            for (int i = 0; i < epcs_pkg::NCOND; i++) begin
                cur_set_q[i] <= (sav_set_q[i] == 16'h0000) ? def_set_q[i]
                    : sav_set_q[i]; // RULE11
            end
        end
    end

    // Run flags follow the feature state and enables
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            run_q <= 4'h0;
        end else if (cmd_go && !abort && is_dis) begin
            run_q <= 4'h0; // RULE16
        end else if (cmd_go && !abort && is_en) begin
            for (int i = 0; i < epcs_pkg::NCOND; i++) begin
                // Uses the freshly loaded setting
                run_q[i] <= cur_en_q[i] && ((sav_set_q[i] != 16'h0000)
                    || (def_set_q[i] != 16'h0000)); // RULE12
            end
        end else if (cmd_go && !abort && is_state) begin
            run_q[cid] <= feat_q && cmd.number[epcs_pkg::SN_EN_BIT]
                && (cur_set_q[cid] != 16'h0000); // RULE7
        end
    end

    // ==========================================================
    // Status and error
    // ==========================================================
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            status_q <= epcs_pkg::STATUS_RST;
            error_q <= 8'h00;
        end else if (cmd_go) begin
            // Completion within the write's data phase
            status_q <= 8'h00;
            status_q[epcs_pkg::ST_RDY] <= 1'b1; // RULE19
            status_q[epcs_pkg::ST_ERR] <= abort; // RULE19
            error_q <= 8'h00;
            error_q[epcs_pkg::ER_ABT] <= abort; // RULE19
        end
    end

    // ==========================================================
    // Read data
    // ==========================================================
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rdata_q <= 32'h0000_0000;
        end else if (hready && hsel && htrans[1] && !hwrite) begin
            case (haddr[7:0])
                epcs_pkg::CTRL_OFF: rdata_q <= {18'h00000, disabling_q,
                    feat_sup_q, savable_q, change_q, support_q};
                epcs_pkg::STAT_OFF: rdata_q <= {13'h0000, id_bit_q, apm_q,
                    feat_q, error_q, status_q};
                epcs_pkg::TMR_OFF: rdata_q <= {20'h00000, run_q, sav_en_q,
                    cur_en_q};
                epcs_pkg::CUR_OFF: rdata_q <= {cur_set_q[1], cur_set_q[0]};
                default: rdata_q <= 32'h0000_0000;
            endcase
        end
    end

    // Read strobe kept for symmetry; nothing needs it at zero wait
    logic rd_unused;
    assign hrdata = rdata_q;
    assign rd_unused = rd_q;
    assign extended_power_conditions_on = feat_q;
    assign advanced_power_mgmt_on = apm_q;
    assign timer_run = run_q;
    assign nv_feature_wr = nv_wr_q;
    assign nv_feature_val = nv_val_q;
endmodule : epcs_top
`default_nettype wire

// ==== epcs_sva.sv ====
// Port checker for the power condition subcommand block
`timescale 1ns/1ps
`default_nettype none
module epcs_sva (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hreadyout,
    input wire logic hresp,
    input wire logic extended_power_conditions_on,
    input wire logic advanced_power_mgmt_on,
    input wire logic [3:0] timer_run,
    input wire logic nv_feature_wr,
    input wire logic nv_feature_val
);
    // ==========================================================
    // Relations between outputs over time
    // ==========================================================
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    // Zero wait slave with OKAY only
    chk_ready_high: assert property (hreadyout)
        else $error("hreadyout low");
    chk_resp_okay: assert property (!hresp)
        else $error("hresp not okay");
    chk_wr_pulse: assert property (nv_feature_wr |=> !nv_feature_wr)
        else $error("store strobe longer than one cycle");
    chk_wr_value: assert property (nv_feature_wr |->
        nv_feature_val == extended_power_conditions_on)
        else $error("stored value differs from feature state");
    chk_apm_off: assert property (extended_power_conditions_on |->
        !advanced_power_mgmt_on)
        else $error("power management on with feature set on");
    chk_timer_gate: assert property (timer_run != 4'h0 |->
        extended_power_conditions_on)
        else $error("timer runs with feature set off");
    chk_stop_all: assert property ($fell(extended_power_conditions_on) |->
        timer_run == 4'h0)
        else $error("timers left running after disable");
    // Past depth two skips the load edge after reset release
    chk_store_follows: assert property ($changed(extended_power_conditions_on)
        && $past(hresetn, 2) |-> ##[0:1] nv_feature_wr)
        else $error("feature change not sent to store");
    cov_enable: cover property ($rose(extended_power_conditions_on));
    cov_disable: cover property ($fell(extended_power_conditions_on));
    cov_all_run: cover property (timer_run == 4'hf);
endmodule : epcs_sva
bind epcs_top epcs_sva u_sva (.hclk(hclk), .hresetn(hresetn),
    .hreadyout(hreadyout), .hresp(hresp),
    .extended_power_conditions_on(extended_power_conditions_on),
    .advanced_power_mgmt_on(advanced_power_mgmt_on),
    .timer_run(timer_run), .nv_feature_wr(nv_feature_wr),
    .nv_feature_val(nv_feature_val));
`default_nettype wire

// ==== epcs_nv_model.sv ====
// Nonvolatile store model holding the feature state across resets
`timescale 1ns/1ps
`default_nettype none
module epcs_nv_model #(
    parameter logic INIT = 1'b0 // Blank store reads off
) (
    input wire logic hclk,
    input wire logic nv_feature_wr,
    input wire logic nv_feature_val,
    output logic nv_feature_on
);
    // ==========================================================
    // Store, deliberately blind to hresetn
    // ==========================================================
    logic stored_q = INIT;
    // Write strobe updates the kept state
    always @(posedge hclk) begin
        if (nv_feature_wr === 1'b1) begin
            stored_q <= nv_feature_val;
        end
    end
    assign nv_feature_on = stored_q;
endmodule : epcs_nv_model
`default_nettype wire

// ==== epcs_power_condition_subcommands_test.sv ====
// Self-checking bench for the power condition subcommand block
`timescale 1ns/1ps
`default_nettype none
module epcs_power_condition_subcommands_test;
    // ==========================================================
    // Signals and bench model state
    // ==========================================================
    logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp;
    logic [31:0] haddr, hwdata, hrdata, rd, lf;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic f_on, apm_on, nv_on, nv_wr, nv_val, feat, advanced_power_mgmt, dis, fsup;
    logic [3:0] run, runm, cen, sen, sup, chg, sav;
    logic [7:0] st, er;
    logic [15:0] cur [4];
    logic [15:0] sv [4];
    int n_errors, total_checks, i;
    assign hready = hreadyout;
    initial begin
        hclk = 1'b0;
        forever #4 hclk = ~hclk;
    end
    epcs_top u_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
        .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp),
        .extended_power_conditions_on(f_on), .advanced_power_mgmt_on(apm_on),
        .timer_run(run), .nv_feature_on(nv_on), .nv_feature_wr(nv_wr),
        .nv_feature_val(nv_val));
    epcs_nv_model u_nv (.hclk(hclk), .nv_feature_wr(nv_wr),
        .nv_feature_val(nv_val), .nv_feature_on(nv_on));
    // ==========================================================
    // Tasks
    // ==========================================================
    function automatic logic [31:0] lfsr(input logic [31:0] v);
        return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction : lfsr
    task finish_test;
        $display("checks %0d mismatches %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask : finish_test
    task chk(input string name, input logic [31:0] exp, got);
        total_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("mismatch %s expected %h seen %h", name, exp, got);
        end
    endtask : chk
    // Bounded wait; a stuck bus ends the run
    task wait_rdy;
        int k;
        k = 0;
        do begin
            @(posedge hclk);
            k++;
        end while (hready !== 1'b1 && k < 64);
        if (hready !== 1'b1) begin
            n_errors++;
            finish_test;
        end
    endtask : wait_rdy
    // One single AHB-Lite word transfer; read data lands in rd
    task bus(input logic w, input logic [7:0] a, input logic [31:0] wd);
        hsel <= 1'b1;
        haddr <= {24'h0, a};
        hwrite <= w;
        htrans <= 2'b10;
        wait_rdy;
        htrans <= 2'b00;
        hwdata <= wd;
        wait_rdy;
        rd = hrdata;
    endtask : bus
    task set_ctrl(input logic [13:0] v);
        {dis, fsup, sav, chg, sup} = v;
        bus(1'b1, epcs_pkg::CTRL_OFF, {18'h0, v});
    endtask : set_ctrl
    // Model outcome first, then send the command word
    task do_cmd(input logic [7:0] cnt, num);
        logic ab;
        int c;
        c = cnt[1:0];
        case (num[3:0])
            epcs_pkg::SUB_STATE: begin
                ab = !sup[c] || !chg[c] || dis || (num[4] && !sav[c]);
                if (!ab) cen[c] = num[5];
                if (!ab && num[4]) sen[c] = num[5];
            end
            epcs_pkg::SUB_ENABLE: begin
                ab = !fsup;
                if (!ab) {feat, advanced_power_mgmt} = 2'b10;
                for (int j = 0; j < 4 && !ab; j++) begin
                    cur[j] = sv[j] == 0 ? epcs_pkg::DEF_TIMER_RST : sv[j];
                end
            end
            epcs_pkg::SUB_DISABLE: begin
                ab = !fsup || dis;
                if (!ab) feat = 1'b0;
            end
            default: ab = 1'b1;
        endcase
        st = ab ? 8'h41 : 8'h40;
        er = ab ? 8'h04 : 8'h00;
        bus(1'b1, epcs_pkg::CMD_OFF, {8'h0, epcs_pkg::FEAT_EPC, cnt, num});
    endtask : do_cmd
    // Status always; timers and settings when full is set
    task check(input logic full, input string tname);
        for (int j = 0; j < 4; j++) runm[j] = feat && cen[j] && cur[j] != 0;
        bus(1'b0, epcs_pkg::STAT_OFF, 32'h0);
        chk("status", {13'h0, feat, advanced_power_mgmt, feat, er, st}, rd);
        if (full) begin
            bus(1'b0, epcs_pkg::TMR_OFF, 32'h0);
            chk("timers", {20'h0, runm, sen, cen}, rd);
            chk("timer_run", {28'h0, runm}, {28'h0, run});
            bus(1'b0, epcs_pkg::CUR_OFF, 32'h0);
            chk("current", {cur[1], cur[0]}, rd);
        end
        $display("test %s done", tname);
    endtask : check
    task rst_pulse;
        hresetn <= 1'b0;
        repeat (16) @(posedge hclk);
        hresetn <= 1'b1;
        repeat (2) @(posedge hclk);
        {dis, fsup, sav, chg, sup} = 14'h1fff;
        // Enables and saved settings are volatile: back to reset values
        cen = 4'hf;
        sen = 4'hf;
        sv = '{16'h0, 16'h0, 16'h0, 16'h0};
        advanced_power_mgmt = !feat;
        {st, er} = 16'h4000;
    endtask : rst_pulse
    // ==========================================================
    // Main sequence
    // ==========================================================
    initial begin
        {hsel, hwrite, htrans, haddr, hwdata} = '0;
        hsize = 3'b010;
        hresetn = 1'b0;
        lf = 32'h7d4f;
        n_errors = 0;
        total_checks = 0;
        feat = 1'b0;
        cen = 4'hf;
        sen = 4'hf;
        sv = '{16'h0, 16'h0, 16'h0, 16'h0};
        feat = 1'b1;
        rst_pulse;
        feat = 1'b0;
        advanced_power_mgmt = 1'b1;
        check(1'b0, "reset");
        bus(1'b0, 8'h40, 32'h0);
        chk("unmapped", 32'h0, rd);
        bus(1'b1, epcs_pkg::SAV_OFF, {14'h0, 2'd1, 16'h0123});
        sv[1] = 16'h0123;
        do_cmd(8'h00, 8'h04);
        check(1'b1, "enable");
        for (i = 0; i < 16; i++) begin
            lf = lfsr(lf);
            set_ctrl({2'b01, lf[11:8], lf[7:4] | lf[15:12], lf[3:0] | lf[19:16]});
            do_cmd({6'h0, lf[21:20]}, {2'b00, lf[23:22], 4'h3});
            check(1'b1, "state");
        end
        do_cmd(8'h00, 8'h07);
        check(1'b1, "bad code");
        set_ctrl(14'h3fff);
        do_cmd(8'h00, 8'h05);
        check(1'b1, "disabling");
        do_cmd(8'h01, 8'h23);
        check(1'b1, "state while disabling");
        set_ctrl(14'h0fff);
        do_cmd(8'h00, 8'h04);
        check(1'b1, "no support");
        rst_pulse;
        check(1'b0, "kept on");
        do_cmd(8'h00, 8'h04);
        check(1'b1, "re-enable");
        do_cmd(8'h00, 8'h05);
        check(1'b1, "disable");
        chk("timer_run", 32'h0, {28'h0, run});
        rst_pulse;
        check(1'b0, "kept off");
        finish_test;
    end
endmodule : epcs_power_condition_subcommands_test
`default_nettype wire
